// ### design/cce_map.svh
// Purpose: Offsets, codes and limits of the configuration intake block
// Assumes: 16-bit backplane words, word indices within a 64-word block
// Notes: Definitions only
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH
`define CCE_BLK_WORDS 7'h40
`define CCE_ID_CFG 16'h2328
`define CCE_ID_ANS 16'hfffe
`define CCE_CTL_LO 16'h270d
`define CCE_CTL_HI 16'h270f
`define CCE_DB_SIZE 16'h1388
`define CCE_DB_LAST 13'h1387
`define CCE_W_ID 6'h00
`define CCE_W_WR_START 6'h01
`define CCE_W_WR_COUNT 6'h02
`define CCE_W_RD_START 6'h03
`define CCE_W_RD_COUNT 6'h04
`define CCE_W_P1_FIRST 6'h07
`define CCE_W_P1_LAST 6'h1f
`define CCE_W_P2_FIRST 6'h20
`define CCE_W_P2_LAST 6'h38
`define CCE_A_ID 6'h00
`define CCE_A_ECHO 6'h01
`define CCE_A_MOD_ERR 6'h02
`define CCE_A_P1_ERR 6'h03
`define CCE_A_P2_ERR 6'h04
`define CCE_P_ROLE 5'h00
`define CCE_P_FLT_EN 5'h01
`define CCE_P_FLT_START 5'h02
`define CCE_P_FLT_OFS 5'h03
`define CCE_P_PROTO 5'h04
`define CCE_P_BAUD 5'h05
`define CCE_P_PARITY 5'h06
`define CCE_P_DBITS 5'h07
`define CCE_P_SBITS 5'h08
`define CCE_P_SLAVE 5'h09
`define CCE_P_OFS_FIRST 5'h0a
`define CCE_P_CMD_CNT 5'h0e
`define CCE_P_WORDS 5'h19
`define CCE_MAX_CMDS 16'h0064
`define CCE_MAX_SLAVE 16'h00f7
`define CCE_MAX_PARITY 16'h0004
`define CCE_MIN_DBITS 16'h0005
`define CCE_MAX_DBITS 16'h0008
`define CCE_MAX_SBITS 16'h0002
`define CCE_MAX_NODE 16'h00ff
`define CCE_MAX_ENABLE 16'h0002
`define CCE_MAX_SWAP 16'h0003
`define CCE_ERR_CTS 16'hffff
`define CCE_ERR_TX_TO 16'hfffe
`define CCE_ERR_RSP_TO 16'hfff5
`define CCE_ERR_ADDR 16'h00fd
`define CCE_ERR_FUNC 16'h00fe
`define CCE_ERR_CRC 16'h00ff
`define CCE_ERR_ENABLE 16'hffd7
`define CCE_ERR_INT_ADDR 16'hffd6
`define CCE_ERR_NODE 16'hffd5
`define CCE_ERR_COUNT 16'hffd4
`define CCE_ERR_FUNCODE 16'hffd3
`define CCE_ERR_SWAP 16'hffd2
`define CCE_EXC_MIN 8'h01
`define CCE_EXC_MAX 8'h06
`endif

// ### design/cce_pkg.sv
// Purpose: Types shared by the configuration intake block
// Assumes: Offsets and codes live in cce_map.svh
// Notes: Nothing here is imported; users write cce_pkg::name
package cce_pkg;
    typedef struct packed {
        logic valid;
        logic last;
        logic [5:0] idx;
        logic [15:0] data;
    } cce_bwt_t;
    typedef enum logic [2:0] {
        CCE_EV_EXC = 3'h0,
        CCE_EV_CTS = 3'h1,
        CCE_EV_TX_TO = 3'h2,
        CCE_EV_RSP_TO = 3'h3,
        CCE_EV_ADDR = 3'h4,
        CCE_EV_FUNC = 3'h5,
        CCE_EV_CRC = 3'h6
    } cce_ev_kind_t;
    typedef struct packed {
        logic valid;
        logic port;
        cce_ev_kind_t kind;
        logic [7:0] exc_code;
    } cce_cmd_ev_t;
    typedef struct packed {
        logic valid;
        logic port;
        logic [15:0] enable;
        logic [15:0] int_addr;
        logic [15:0] node;
        logic [15:0] count;
        logic [15:0] func;
        logic [15:0] swap;
    } cce_cmd_entry_t;
    typedef struct packed {
        logic wr_en;
        logic [12:0] addr;
        logic [15:0] data;
    } cce_db_req_t;
    typedef enum logic [3:0] {
        CCE_ST_IDLE = 4'b0001,
        CCE_ST_COLLECT = 4'b0010,
        CCE_ST_CHECK = 4'b0100,
        CCE_ST_ANSWER = 4'b1000
    } cce_state_t;
endpackage

// ### design/cce_port_check.sv
// Purpose: Validates one serial port's 25 setup words into an error word
// Assumes: Words indexed from the first word of that port's setup area
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/10ps
`include "cce_map.svh"
module cce_port_check (
    input wire logic [24:0][15:0] words,
    output logic [15:0] err
);
    function automatic logic db_bad(input logic [15:0] v);
        db_bad = v[15] || (v >= `CCE_DB_SIZE);
    endfunction

    function automatic logic baud_bad(input logic [15:0] v);
        case (v)
            16'h006e, 16'h0096, 16'h012c, 16'h0258, 16'h04b0, 16'h0960, 16'h12c0,
            16'h2580, 16'h4b00, 16'h7080, 16'h9600, 16'he100: baud_bad = 1'b0;
            // Rates above 57600 do not fit 16 bits; written as hundreds
            16'h0480: baud_bad = 1'b0;
            default: baud_bad = 1'b1;
        endcase
    endfunction

    wire logic ofs_bad = db_bad(words[`CCE_P_OFS_FIRST]) || db_bad(words[`CCE_P_OFS_FIRST + 5'h01]) ||
        db_bad(words[`CCE_P_OFS_FIRST + 5'h02]) || db_bad(words[`CCE_P_OFS_FIRST + 5'h03]);

    always_comb begin
        err = 16'h0000;
        err[0] = words[`CCE_P_ROLE] > 16'h0001;
        err[1] = words[`CCE_P_FLT_EN] > 16'h0001;
        err[2] = db_bad(words[`CCE_P_FLT_START]);
        err[3] = db_bad(words[`CCE_P_FLT_OFS]);
        err[4] = words[`CCE_P_PROTO] > 16'h0001;
        err[5] = baud_bad(words[`CCE_P_BAUD]);
        err[6] = words[`CCE_P_PARITY] > `CCE_MAX_PARITY;
        err[7] = (words[`CCE_P_DBITS] < `CCE_MIN_DBITS) || (words[`CCE_P_DBITS] > `CCE_MAX_DBITS);
        err[8] = (words[`CCE_P_SBITS] == 16'h0000) || (words[`CCE_P_SBITS] > `CCE_MAX_SBITS);
        err[9] = (words[`CCE_P_SLAVE] == 16'h0000) || (words[`CCE_P_SLAVE] > `CCE_MAX_SLAVE);
        err[10] = ofs_bad;
        err[11] = words[`CCE_P_CMD_CNT] > `CCE_MAX_CMDS;
    end
endmodule

// ### design/cce_config_check.sv
// Purpose: Configuration intake, setup error answer, command error codes and shared database
// Assumes: Backplane words arrive at most one per cycle, synchronous to sys_clk
// Notes: Answer block is read word by word, one cycle after the request
//
// Summary of operation
// - A write block whose word 0 is 9000 starts the configuration procedure.
// - Words 1-6 backplane setup, 7-31 port one, 32-56 port two, rest spare.
// - After checking, a read block with identifier -2 carries the errors found.
// - Answer: id at 0, 9000 at 1, module, port one, port two errors at 2-4.
// - Module error bit 0: write start above size; bit 1: write start negative.
// - Bit 2: write count negative; bit 3: write count plus start above size.
// - Bit 4: read start above size; bit 5: read start negative.
// - Bit 6: read count negative; bit 7: read count plus start above size.
// - Port error bit 0 when role is neither master 0 nor slave 1.
// - Port bits 1-3 flag bad float enable, float start, float offset.
// - Port bits 4-8 flag bad protocol, baud, parity, data bits, stop bits.
// - Port bit 9 flags a bad slave identifier.
// - Port bit 10 flags any bad input, output or holding offset.
// - Port bit 11 flags a bad command count; bits 12-15 spare.
// - A slave exception code from 1 to 6 is recorded for the command.
// - Record -1 for missing CTS, -2 transmit timeout, -11 response timeout.
// - Record 253 wrong address, 254 wrong function, 255 bad check value.
// - Command entries checked; codes -41 to -46 for the six entry faults.
// - Database of 5000 sixteen-bit words, shared by Modbus and backplane.
// - Each backplane transfer carries at most 64 words.
// - Two ports, each set independently as Modbus master or slave.
`timescale 1ns/10ps
`include "cce_map.svh"
module cce_config_check (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cce_pkg::cce_bwt_t bwt_in,
    input wire logic brt_rd_en,
    input wire logic [5:0] brt_rd_idx,
    input wire cce_pkg::cce_cmd_ev_t cmd_ev,
    input wire cce_pkg::cce_cmd_entry_t cmd_entry,
    input wire cce_pkg::cce_db_req_t db_mb_req,
    input wire cce_pkg::cce_db_req_t db_bp_req,
    output logic [15:0] brt_rd_data,
    output logic brt_rd_valid,
    output logic brt_avail,
    output logic cfg_busy,
    output logic boot_req,
    output logic [15:0] ctl_code,
    output logic [1:0] port_slave,
    output logic [15:0] p1_cmd_err,
    output logic [15:0] p2_cmd_err,
    output logic [15:0] entry_err,
    output logic entry_err_valid,
    output logic [15:0] db_mb_rdata,
    output logic [15:0] db_bp_rdata
);
    logic rst_meta_q;
    logic rst_sync_q;
    wire logic rst_ok_n = rst_sync_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    function automatic logic [3:0] area_err(input logic [15:0] start, input logic [15:0] count);
        logic [16:0] sum;
        sum = {start[15], start} + {count[15], count};
        area_err = 4'h0;
        area_err[0] = !start[15] && (start > `CCE_DB_SIZE);
        area_err[1] = start[15];
        area_err[2] = count[15];
        area_err[3] = !sum[16] && (sum[15:0] > `CCE_DB_SIZE);
    endfunction

    function automatic logic [15:0] entry_code(input cce_pkg::cce_cmd_entry_t e);
        logic func_ok;
        func_ok = (e.func >= 16'h0001 && e.func <= 16'h0006) || e.func == 16'h000f || e.func == 16'h0010;
        if (e.enable > `CCE_MAX_ENABLE) begin
            entry_code = `CCE_ERR_ENABLE;
        end else if (e.int_addr > {3'h0, `CCE_DB_LAST}) begin
            entry_code = `CCE_ERR_INT_ADDR;
        end else if (e.node[15] || e.node > `CCE_MAX_NODE) begin
            entry_code = `CCE_ERR_NODE;
        end else if (e.count == 16'h0000) begin
            entry_code = `CCE_ERR_COUNT;
        end else if (!func_ok) begin
            entry_code = `CCE_ERR_FUNCODE;
        end else if (e.swap > `CCE_MAX_SWAP) begin
            entry_code = `CCE_ERR_SWAP;
        end else begin
            entry_code = 16'h0000;
        end
    endfunction

    cce_pkg::cce_state_t st_q;
    cce_pkg::cce_state_t st_d;
    logic [63:0][15:0] cfg_q;
    logic [15:0] mod_err_q;
    logic [15:0] p1_err_q;
    logic [15:0] p2_err_q;
    logic [6:0] wcnt_q;
    logic brt_avail_q;
    logic cfg_busy_q;
    logic boot_q;
    logic [15:0] ctl_q;
    logic [1:0] slave_q;
    logic [15:0] brt_data_q;
    logic brt_valid_q;
    logic [15:0] p1_cmd_q;
    logic [15:0] p2_cmd_q;
    logic [15:0] entry_q;
    logic entry_v_q;
    logic [15:0] db_q [0:4999];
    logic [15:0] db_mb_q;
    logic [15:0] db_bp_q;

    wire logic [15:0] p1_err_w;
    wire logic [15:0] p2_err_w;

    cce_port_check u_p1 (
        .words(cfg_q[`CCE_W_P1_LAST:`CCE_W_P1_FIRST]),
        .err(p1_err_w)
    );
    cce_port_check u_p2 (
        .words(cfg_q[`CCE_W_P2_LAST:`CCE_W_P2_FIRST]),
        .err(p2_err_w)
    );

    wire logic cfg_start = bwt_in.valid && bwt_in.idx == `CCE_W_ID && bwt_in.data == `CCE_ID_CFG;
    wire logic ctl_hit = bwt_in.valid && bwt_in.idx == `CCE_W_ID &&
        bwt_in.data >= `CCE_CTL_LO && bwt_in.data <= `CCE_CTL_HI;
    // Words past the 64th would alias; the count guard drops them
    wire logic word_ok = bwt_in.valid && wcnt_q < `CCE_BLK_WORDS;
    wire logic [15:0] mod_err_w = {8'h00, area_err(cfg_q[`CCE_W_RD_START], cfg_q[`CCE_W_RD_COUNT]),
        area_err(cfg_q[`CCE_W_WR_START], cfg_q[`CCE_W_WR_COUNT])};
    wire logic [15:0] ans_w = (brt_rd_idx == `CCE_A_ID) ? `CCE_ID_ANS :
        (brt_rd_idx == `CCE_A_ECHO) ? `CCE_ID_CFG :
        (brt_rd_idx == `CCE_A_MOD_ERR) ? mod_err_q :
        (brt_rd_idx == `CCE_A_P1_ERR) ? p1_err_q :
        (brt_rd_idx == `CCE_A_P2_ERR) ? p2_err_q : 16'h0000;
    wire logic [15:0] ev_code = (cmd_ev.kind == cce_pkg::CCE_EV_EXC) ? {8'h00, cmd_ev.exc_code} :
        (cmd_ev.kind == cce_pkg::CCE_EV_CTS) ? `CCE_ERR_CTS :
        (cmd_ev.kind == cce_pkg::CCE_EV_TX_TO) ? `CCE_ERR_TX_TO :
        (cmd_ev.kind == cce_pkg::CCE_EV_RSP_TO) ? `CCE_ERR_RSP_TO :
        (cmd_ev.kind == cce_pkg::CCE_EV_ADDR) ? `CCE_ERR_ADDR :
        (cmd_ev.kind == cce_pkg::CCE_EV_FUNC) ? `CCE_ERR_FUNC : `CCE_ERR_CRC;
    wire logic exc_ok = cmd_ev.exc_code >= `CCE_EXC_MIN && cmd_ev.exc_code <= `CCE_EXC_MAX;
    wire logic ev_take = cmd_ev.valid && (cmd_ev.kind != cce_pkg::CCE_EV_EXC || exc_ok);
    wire logic mb_in_range = db_mb_req.addr <= `CCE_DB_LAST;
    wire logic bp_in_range = db_bp_req.addr <= `CCE_DB_LAST;

    always_comb begin
        st_d = st_q;
        case (st_q)
            cce_pkg::CCE_ST_IDLE, cce_pkg::CCE_ST_ANSWER: begin
                if (cfg_start && !bwt_in.last) begin
                    st_d = cce_pkg::CCE_ST_COLLECT;
                end else if (cfg_start) begin
                    st_d = cce_pkg::CCE_ST_CHECK;
                end
            end
            cce_pkg::CCE_ST_COLLECT: begin
                if (bwt_in.valid && (bwt_in.last || wcnt_q == `CCE_BLK_WORDS - 7'h01)) begin
                    st_d = cce_pkg::CCE_ST_CHECK;
                end
            end
            cce_pkg::CCE_ST_CHECK: begin
                st_d = cce_pkg::CCE_ST_ANSWER;
            end
            default: begin
                st_d = cce_pkg::CCE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            st_q <= cce_pkg::CCE_ST_IDLE;
            wcnt_q <= 7'h00;
        end else begin
            st_q <= st_d;
            if (cfg_start) begin
                wcnt_q <= 7'h01;
            end else if (st_q == cce_pkg::CCE_ST_COLLECT && word_ok) begin
                wcnt_q <= wcnt_q + 7'h01;
            end
        end
    end

    // Spare words are stored but never checked
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            cfg_q <= '0;
        end else if (cfg_start) begin
            cfg_q <= '0;
        end else if (st_q == cce_pkg::CCE_ST_COLLECT && word_ok) begin
            cfg_q[bwt_in.idx] <= bwt_in.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            mod_err_q <= 16'h0000;
            p1_err_q <= 16'h0000;
            p2_err_q <= 16'h0000;
            slave_q <= 2'b00;
        end else if (st_q == cce_pkg::CCE_ST_CHECK) begin
            mod_err_q <= mod_err_w;
            p1_err_q <= p1_err_w;
            p2_err_q <= p2_err_w;
            slave_q <= {cfg_q[`CCE_W_P2_FIRST][0], cfg_q[`CCE_W_P1_FIRST][0]};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            brt_avail_q <= 1'b0;
            cfg_busy_q <= 1'b0;
            boot_q <= 1'b0;
            ctl_q <= 16'h0000;
        end else begin
            brt_avail_q <= st_d == cce_pkg::CCE_ST_ANSWER;
            cfg_busy_q <= st_d == cce_pkg::CCE_ST_COLLECT || st_d == cce_pkg::CCE_ST_CHECK;
            boot_q <= ctl_hit;
            if (ctl_hit) begin
                ctl_q <= bwt_in.data;
            end
        end
    end

    // Answer words are only meaningful once the check has finished
    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            brt_data_q <= 16'h0000;
            brt_valid_q <= 1'b0;
        end else begin
            brt_valid_q <= brt_rd_en && brt_avail_q;
            if (brt_rd_en && brt_avail_q) begin
                brt_data_q <= ans_w;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            p1_cmd_q <= 16'h0000;
            p2_cmd_q <= 16'h0000;
        end else if (ev_take && !cmd_ev.port) begin
            p1_cmd_q <= ev_code;
        end else if (ev_take) begin
            p2_cmd_q <= ev_code;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            entry_q <= 16'h0000;
            entry_v_q <= 1'b0;
        end else begin
            entry_v_q <= cmd_entry.valid;
            if (cmd_entry.valid) begin
                entry_q <= entry_code(cmd_entry);
            end
        end
    end

    // Backplane write wins a same-address collision; Modbus write is lost then
    always_ff @(posedge sys_clk) begin
        if (db_bp_req.wr_en && bp_in_range) begin
            db_q[db_bp_req.addr] <= db_bp_req.data;
        end
        if (db_mb_req.wr_en && mb_in_range && !(db_bp_req.wr_en && db_bp_req.addr == db_mb_req.addr)) begin
            db_q[db_mb_req.addr] <= db_mb_req.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            db_mb_q <= 16'h0000;
            db_bp_q <= 16'h0000;
        end else begin
            db_mb_q <= mb_in_range ? db_q[db_mb_req.addr] : 16'h0000;
            db_bp_q <= bp_in_range ? db_q[db_bp_req.addr] : 16'h0000;
        end
    end

    assign brt_rd_data = brt_data_q;
    assign brt_rd_valid = brt_valid_q;
    assign brt_avail = brt_avail_q;
    assign cfg_busy = cfg_busy_q;
    assign boot_req = boot_q;
    assign ctl_code = ctl_q;
    assign port_slave = slave_q;
    assign p1_cmd_err = p1_cmd_q;
    assign p2_cmd_err = p2_cmd_q;
    assign entry_err = entry_q;
    assign entry_err_valid = entry_v_q;
    assign db_mb_rdata = db_mb_q;
    assign db_bp_rdata = db_bp_q;
endmodule

// ### test/cce_config_check_assertions.sv
// Purpose: Port-level checks of the configuration intake block
// Assumes: Only top-level ports are visible
// Notes: Bound to every instance of the top module
`timescale 1ns/10ps
module cce_config_check_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cce_pkg::cce_bwt_t bwt_in,
    input wire logic brt_rd_en,
    input wire logic [5:0] brt_rd_idx,
    input wire cce_pkg::cce_cmd_ev_t cmd_ev,
    input wire cce_pkg::cce_db_req_t db_bp_req,
    input wire logic [15:0] brt_rd_data,
    input wire logic brt_rd_valid,
    input wire logic brt_avail,
    input wire logic cfg_busy,
    input wire logic [15:0] p1_cmd_err,
    input wire logic [15:0] p2_cmd_err,
    input wire logic [15:0] db_bp_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire rd_ok = brt_rd_en && brt_avail;

    rd_answer_a: assert property (rd_ok |=> brt_rd_valid)
        else $error("answer read not acknowledged");
    rd_refuse_a: assert property (brt_rd_en && !brt_avail |=> !brt_rd_valid)
        else $error("answer read acknowledged while not ready");
    ans_id_a: assert property (rd_ok && brt_rd_idx == 6'h00 |=> brt_rd_data == 16'hfffe)
        else $error("answer identifier wrong");
    ans_spare_a: assert property (rd_ok && brt_rd_idx > 6'h04 |=> brt_rd_data == 16'h0000)
        else $error("spare answer word not zero");
    cfg_start_a: assert property (bwt_in.valid && bwt_in.idx == 6'h00 && bwt_in.data == 16'h2328
        && !cfg_busy |=> cfg_busy) else $error("start word did not start intake");
    chk_done_a: assert property (bwt_in.valid && bwt_in.last && cfg_busy
        |=> !brt_avail ##1 (brt_avail && !cfg_busy)) else $error("answer not ready two cycles after last");
    exc_code_a: assert property (cmd_ev.valid && cmd_ev.kind == cce_pkg::CCE_EV_EXC
        && cmd_ev.exc_code inside {[8'h01:8'h06]}
        |=> ($past(cmd_ev.port) ? p2_cmd_err : p1_cmd_err) == {8'h00, $past(cmd_ev.exc_code)})
        else $error("exception code not recorded");
    db_range_a: assert property (db_bp_req.addr > 13'h1387 |=> db_bp_rdata == 16'h0000)
        else $error("read beyond database not zero");
endmodule

bind cce_config_check cce_config_check_chk u_chk (
    .sys_clk, .rst_n, .bwt_in, .brt_rd_en, .brt_rd_idx, .cmd_ev, .db_bp_req, .brt_rd_data,
    .brt_rd_valid, .brt_avail, .cfg_busy, .p1_cmd_err, .p2_cmd_err, .db_bp_rdata
);

// ### test/cce_plc_model.sv
// Purpose: Controller side model sending setup blocks over the backplane
// Assumes: One word a cycle, or one every two cycles when slow
// Notes: Idle bus shows the inverted last word, never a stale copy
`timescale 1ns/10ps
module cce_plc_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic slow,
    input wire logic [6:0] n_words,
    input wire logic [63:0][15:0] blk,
    output cce_pkg::cce_bwt_t bwt,
    output logic busy
);
    initial begin
        bwt = '0;
        busy = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (go) begin
                busy = 1'b1;
                for (int i = 0; i < n_words && i < 64; i++) begin
                    #2 bwt = '{1'b1, i == n_words - 1, 6'(i), blk[i]};
                    @(posedge sys_clk);
                    if (slow || i == n_words - 1) begin
                        #2 bwt = '{1'b0, 1'b0, ~bwt.idx, ~bwt.data};
                        if (slow) @(posedge sys_clk);
                    end
                end
                busy = 1'b0;
            end
        end
    end
endmodule

// ### test/cce_config_check_tb.sv
// Purpose: Self-checking bench for the configuration intake block
// Assumes: Partner model sends setup blocks; bench reads the answer
// Notes: Random setups come from a fixed-seed shift register
`timescale 1ns/10ps
module cce_config_check_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic m_busy;
    logic [6:0] n_words = 7'h40;
    logic [63:0][15:0] blk = '0;
    cce_pkg::cce_bwt_t bwt_in;
    logic brt_rd_en = 1'b0;
    logic [5:0] brt_rd_idx = 6'h00;
    cce_pkg::cce_cmd_ev_t cmd_ev = '0;
    cce_pkg::cce_cmd_entry_t cmd_entry = '0;
    cce_pkg::cce_db_req_t db_mb_req = '0;
    cce_pkg::cce_db_req_t db_bp_req = '0;
    logic brt_rd_valid, brt_avail, cfg_busy, boot_req, entry_err_valid;
    logic [1:0] port_slave;
    logic [15:0] brt_rd_data, ctl_code, p1_cmd_err, p2_cmd_err, entry_err, db_mb_rdata, db_bp_rdata;
    logic [31:0] lfsr = 32'h58f96dc6;
    int err_count = 0;
    int checks_done = 0;
    logic [15:0] good_w [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h2580, 16'h0000,
        16'h0008, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] bad_w [15] = '{16'h0002, 16'h0002, 16'h1388, 16'h1388, 16'h0002, 16'h0064, 16'h0005,
        16'h0004, 16'h0003, 16'h0000, 16'h1388, 16'h1388, 16'h1388, 16'h1388, 16'h0065};
    logic [15:0] corner [8] = '{16'h0000, 16'h0001, 16'h1387, 16'h1388, 16'h1389, 16'hffff, 16'h8000, 16'h7fff};
    logic [15:0] ev_code [7] = '{16'h0000, 16'hffff, 16'hfffe, 16'hfff5, 16'h00fd, 16'h00fe, 16'h00ff};
    logic [15:0] good_e [6] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0003, 16'h0000};
    logic [15:0] bad_e [6] = '{16'h0003, 16'h1388, 16'h0100, 16'h0000, 16'h0007, 16'h0004};

    always #12.5 sys_clk = ~sys_clk;

    cce_config_check uut (.sys_clk, .rst_n, .bwt_in, .brt_rd_en, .brt_rd_idx, .cmd_ev, .cmd_entry,
        .db_mb_req, .db_bp_req, .brt_rd_data, .brt_rd_valid, .brt_avail, .cfg_busy, .boot_req, .ctl_code,
        .port_slave, .p1_cmd_err, .p2_cmd_err, .entry_err, .entry_err_valid, .db_mb_rdata, .db_bp_rdata);
    cce_plc_model u_plc (.sys_clk, .go, .slow, .n_words, .blk, .bwt(bwt_in), .busy(m_busy));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    // Corners half the time, since raw values rarely land near the limits
    function automatic logic [15:0] rnd_val(input logic [31:0] r);
        return r[3] ? r[31:16] : corner[r[2:0]];
    endfunction
    function automatic logic [3:0] area_exp(input logic signed [15:0] s, input logic signed [15:0] c);
        int t;
        t = s + c;
        return {t > 32'sh1388, c < 16'sh0000, s < 16'sh0000, s > 16'sh1388};
    endfunction
    function automatic logic [15:0] port_bit(input int j);
        if (j > 14) return 16'h0000;
        if (j == 14) return 16'h0800;
        if (j > 9) return 16'h0400;
        return 16'h0001 << j;
    endfunction

    task automatic step();
        @(posedge sys_clk);
        #2;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic ok, input logic [15:0] exp);
        brt_rd_idx = idx;
        brt_rd_en = 1'b1;
        step();
        brt_rd_en = 1'b0;
        chk_bit(brt_rd_valid, ok, "answer valid");
        if (ok) chk_word(brt_rd_data, exp, "answer word");
        step();
    endtask
    task automatic run_block(input logic [15:0] ws, wc, rs, rc, input int j1, j2);
        blk = '0;
        blk[0] = 16'h2328;
        blk[1] = ws;
        blk[2] = wc;
        blk[3] = rs;
        blk[4] = rc;
        for (int k = 0; k < 15; k++) begin
            blk[7 + k] = (k == j1) ? bad_w[k] : good_w[k];
            blk[32 + k] = (k == j2) ? bad_w[k] : good_w[k];
        end
        if (j1 != 0) blk[7] = {15'h0000, lfsr[7]};
        if (j2 != 0) blk[32] = {15'h0000, lfsr[8]};
        for (int k = 57; k < 64; k++) blk[k] = lfsr[31:16] + 16'(k);
        go = 1'b1;
        step();
        go = 1'b0;
        for (int k = 0; k < 300 && (m_busy || cfg_busy || !brt_avail); k++) step();
        rd_chk(6'h00, 1'b1, 16'hfffe);
        rd_chk(6'h01, 1'b1, 16'h2328);
        rd_chk(6'h02, 1'b1, {8'h00, area_exp(rs, rc), area_exp(ws, wc)});
        rd_chk(6'h03, 1'b1, port_bit(j1));
        rd_chk(6'h04, 1'b1, port_bit(j2));
        rd_chk(6'h05 + lfsr[5:0] % 6'h3b, 1'b1, 16'h0000);
        chk_word({14'h0000, port_slave}, {14'h0000, blk[32][0], blk[7][0]}, "port roles");
    endtask
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        err_count++;
        wrap_up();
    end

    initial begin
        logic [15:0] v [4];
        logic [15:0] pe [2];
        logic [15:0] f [6];
        int k;
        repeat (12) @(posedge sys_clk);
        #2 rst_n = 1'b1;
        repeat (3) step();
        rd_chk(6'h02, 1'b0, 16'h0000);
        run_block(16'h0000, 16'h000a, 16'h0064, 16'h000a, 15, 15);
        for (int i = 0; i < 24; i++) begin
            for (int m = 0; m < 4; m++) begin
                lfsr = lfsr_next(lfsr);
                v[m] = rnd_val(lfsr);
            end
            slow = lfsr[5];
            n_words = lfsr[6] ? 7'h40 : 7'h39;
            run_block(v[0], v[1], v[2], v[3], int'(lfsr[19:16]), int'(lfsr[23:20]));
        end
        n_words = 7'h01;
        for (int i = 0; i < 4; i++) begin
            blk[0] = 16'h270c + 16'(i);
            go = 1'b1;
            step();
            go = 1'b0;
            step();
            chk_bit(boot_req, i > 0, "boot pulse");
            chk_word(ctl_code, i > 0 ? blk[0] : 16'h0000, "control code");
            step();
            chk_bit(boot_req, 1'b0, "boot pulse end");
        end
        pe[0] = 16'h0000;
        pe[1] = 16'h0000;
        // Codes 0 and 7 are not exceptions and must leave the record alone
        for (int i = 0; i < 28; i++) begin
            k = i % 14;
            cmd_ev = '{1'b1, i > 13, cce_pkg::cce_ev_kind_t'(k < 8 ? 3'h0 : 3'(k - 7)), k < 8 ? 8'(k) : 8'h00};
            if (k > 7) pe[i / 14] = ev_code[k - 7];
            else if (k > 0 && k < 7) pe[i / 14] = 16'(k);
            step();
            cmd_ev = '0;
            chk_word(p1_cmd_err, pe[0], "port one code");
            chk_word(p2_cmd_err, pe[1], "port two code");
            step();
        end
        for (int i = 0; i < 7; i++) begin
            for (int m = 0; m < 6; m++) f[m] = (m == i) ? bad_e[m] : good_e[m];
            cmd_entry = '{1'b1, i[0], f[0], f[1], f[2], f[3], f[4], f[5]};
            step();
            cmd_entry = '0;
            chk_bit(entry_err_valid, 1'b1, "entry flag");
            chk_word(entry_err, i < 6 ? 16'hffd7 - 16'(i) : 16'h0000, "entry code");
            step();
        end
        lfsr = lfsr_next(lfsr);
        db_bp_req = '{1'b1, 13'h1387, lfsr[15:0]};
        db_mb_req = '{1'b1, 13'h0064, lfsr[31:16]};
        step();
        db_mb_req = '{1'b1, 13'h0064, ~lfsr[15:0]};
        db_bp_req = '{1'b1, 13'h0064, lfsr[31:16] ^ 16'h5a5a};
        step();
        db_bp_req = '{1'b0, 13'h1388, 16'h0000};
        db_mb_req = '{1'b0, 13'h1387, 16'h0000};
        step();
        chk_word(db_mb_rdata, lfsr[15:0], "shared word");
        chk_word(db_bp_rdata, 16'h0000, "past the end");
        db_mb_req.addr = 13'h0064;
        step();
        chk_word(db_mb_rdata, lfsr[31:16] ^ 16'h5a5a, "collision winner");
        wrap_up();
    end
endmodule
